// *** bench/bridge_status_indicator_io_tb.sv ***
`timescale 1ns/1ns
module bridge_status_indicator_io_tb import bsi_pkg::*;;
  // ************************************************************
  // signals
  // ************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, led;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic la_o, la_e, lb_o, lb_e, sa_o, sa_e, sb_o, sb_e, dp_o, dp_e;
  logic la_w, lb_w, sa_w, sb_w, dp_w, bt_w, ps_w, pf_w;
  logic press, self_pwr, fault_lvl;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int err_total, comparisons, seed, n, lows0, lows1;
  logic [1:0] lv;

  bsi_io #(.SLOW_HALF(20), .FAST_HALF(10), .FADE_STEP(2)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_state_ind_a_in(la_w), .link_state_ind_a_out(la_o),
    .link_state_ind_a_oe(la_e), .link_state_ind_b_in(lb_w), .link_state_ind_b_out(lb_o),
    .link_state_ind_b_oe(lb_e), .spare_pin_a_in(sa_w), .spare_pin_a_out(sa_o), .spare_pin_a_oe(sa_e),
    .spare_pin_b_in(sb_w), .spare_pin_b_out(sb_o), .spare_pin_b_oe(sb_e), .drive_power_pin_in(dp_w),
    .drive_power_pin_out(dp_o), .drive_power_pin_oe(dp_e), .push_button_in(bt_w),
    .power_source_in(ps_w), .power_fault_in(pf_w), .primary_led_pwm(led));

  bsi_board board_u (.link_a_out(la_o), .link_a_oe(la_e), .link_b_out(lb_o), .link_b_oe(lb_e),
    .spare_a_out(sa_o), .spare_a_oe(sa_e), .spare_b_out(sb_o), .spare_b_oe(sb_e), .dpwr_out(dp_o),
    .dpwr_oe(dp_e), .press(press), .self_pwr(self_pwr), .fault_lvl(fault_lvl), .link_a_wire(la_w),
    .link_b_wire(lb_w), .spare_a_wire(sa_w), .spare_b_wire(sb_w), .dpwr_wire(dp_w),
    .button_wire(bt_w), .source_wire(ps_w), .fault_wire(pf_w));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  // wait for one led change, then count cycles up to the next one
  task automatic half(input int exp);
    n = 0;
    lv[0] = led;
    while (led === lv[0] && n < 200) begin
      n++;
      @(posedge pclk);
    end
    n = 0;
    lv[0] = led;
    while (led === lv[0] && n < 200) begin
      n++;
      @(posedge pclk);
    end
    chk(33'(n), 33'(exp));
  endtask

  task automatic give_verdict();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ************************************************************
  // clock, watchdog and read monitor
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    // about six times the length of the whole sequence
    #200000;
    err_total++;
    give_verdict();
  end

  // every completed read takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) chk(33'h1ffffffff, 33'h0);
      else begin
        e = exp_q.pop_front();
        chk({pslverr, prdata}, e);
      end
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    press = 1'b0;
    self_pwr = 1'b0;
    fault_lvl = 1'b1;
    err_total = 0;
    comparisons = 0;
    seed = 54584;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(BSI_CTRL_OFS, 33'h0);
    rd(BSI_SPARE_OFS, 33'h0);
    chk({la_e, lb_e, sa_e, sb_e, dp_e, led}, 33'h1);
    rd(8'h1c, 33'h100000000);
    apb(1'b1, 8'h10, $random(seed));
    // connected but not loaded: nothing shows yet
    apb(1'b1, BSI_CTRL_OFS, 32'h6);
    chk({la_e, led}, 33'h1);
    apb(1'b1, BSI_CTRL_OFS, 32'h3);
    for (int u = 0; u < 4; u++) begin
      apb(1'b1, BSI_LINK_OFS, 32'(u));
      chk({la_e, lb_e, la_o, lb_o}, {29'h0, 2'h3, 1'(u), 1'(u >> 1)});
      // two synchroniser stages before the pin level reads back
      repeat (2) @(posedge pclk);
      rd(BSI_STAT_OFS, {25'h0, 1'(u >> 1), 1'(u), 6'h24});
    end
    apb(1'b1, BSI_CTRL_OFS, 32'h41);
    chk({la_e, lb_e, dp_e, dp_o, led}, 33'h1);
    for (int i = 0; i < 4; i++) begin
      lv = 2'($random(seed));
      apb(1'b1, BSI_SPARE_OFS, {28'h0, lv, 2'(i)});
      chk({sa_e, sb_e, sa_o, sb_o}, {29'h0, 1'(i), 1'(i >> 1), lv[0], lv[1]});
      repeat (2) @(posedge pclk);
      rd(BSI_STAT_OFS, {25'h0, 2'h0, 1'b1, 1'(i >> 1) & lv[1], 1'(i) & lv[0], 3'h4});
    end
    // short press, released before the read: the flag must still stand
    press <= 1'b1;
    self_pwr <= 1'b1;
    fault_lvl <= 1'b0;
    repeat (4) @(posedge pclk);
    press <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(BSI_STAT_OFS, {24'h0, 1'b1, 3'h1, lv[1], lv[0], 3'h2});
    rd(BSI_STAT_OFS, {24'h0, 1'b0, 3'h1, lv[1], lv[0], 3'h2});
    press <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(BSI_STAT_OFS, {24'h0, 1'b1, 3'h1, lv[1], lv[0], 3'h3});
    press <= 1'b0;
    // a U3 link while connected would fade, so go back to U0 first
    apb(1'b1, BSI_LINK_OFS, 32'h0);
    apb(1'b1, BSI_CTRL_OFS, 32'h5);
    chk(33'(led), 33'h0);
    apb(1'b1, BSI_CTRL_OFS, 32'h15);
    half(20);
    apb(1'b1, BSI_CTRL_OFS, 32'h1d);
    half(10);
    apb(1'b1, BSI_CTRL_OFS, 32'h25);
    lows0 = 0;
    lows1 = 0;
    repeat (700) @(posedge pclk) lows0 += (led === 1'b0);
    repeat (700) @(posedge pclk) lows1 += (led === 1'b0);
    chk(33'(lows0 != lows1 && lows0 > 0 && lows0 < 700), 33'h1);
    apb(1'b1, BSI_CTRL_OFS, 32'h0);
    chk(33'(led), 33'h1);
    give_verdict();
  end
endmodule

// *** bench/bsi_board.sv ***
`timescale 1ns/1ns
// ************************************************************
// board side: pulls on released pins, button and power monitors
// ************************************************************
module bsi_board (
  input wire logic link_a_out,
  input wire logic link_a_oe,
  input wire logic link_b_out,
  input wire logic link_b_oe,
  input wire logic spare_a_out,
  input wire logic spare_a_oe,
  input wire logic spare_b_out,
  input wire logic spare_b_oe,
  input wire logic dpwr_out,
  input wire logic dpwr_oe,
  input wire logic press,
  input wire logic self_pwr,
  input wire logic fault_lvl,
  output logic link_a_wire,
  output logic link_b_wire,
  output logic spare_a_wire,
  output logic spare_b_wire,
  output logic dpwr_wire,
  output logic button_wire,
  output logic source_wire,
  output logic fault_wire
);
  // released pins fall to their pull, never keep the last value
  assign link_a_wire = link_a_oe ? link_a_out : 1'b0;
  assign link_b_wire = link_b_oe ? link_b_out : 1'b0;
  assign spare_a_wire = spare_a_oe ? spare_a_out : 1'b0;
  assign spare_b_wire = spare_b_oe ? spare_b_out : 1'b0;
  assign dpwr_wire = dpwr_oe ? dpwr_out : 1'b1;
  // momentary switch, monitors drive their levels
  assign button_wire = press;
  assign source_wire = self_pwr;
  assign fault_wire = fault_lvl;
endmodule

// *** design/bsi_io.sv ***
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
// status indicators and user pins of the bridge
module bsi_io import bsi_pkg::*; #(
  parameter bit DRIVE_POWER_OPT = 1'b0,
  parameter int SLOW_HALF = BSI_SLOW_HALF,
  parameter int FAST_HALF = BSI_FAST_HALF,
  parameter int FADE_STEP = BSI_FADE_STEP
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_state_ind_a_in,
  output logic link_state_ind_a_out,
  output logic link_state_ind_a_oe,
  input wire logic link_state_ind_b_in,
  output logic link_state_ind_b_out,
  output logic link_state_ind_b_oe,
  input wire logic spare_pin_a_in,
  output logic spare_pin_a_out,
  output logic spare_pin_a_oe,
  input wire logic spare_pin_b_in,
  output logic spare_pin_b_out,
  output logic spare_pin_b_oe,
  input wire logic drive_power_pin_in,
  output logic drive_power_pin_out,
  output logic drive_power_pin_oe,
  input wire logic push_button_in,
  input wire logic power_source_in,
  input wire logic power_fault_in,
  output logic primary_led_pwm
);
  // ************************************************************
  // parameter checks
  // ************************************************************
  initial begin
    if (SLOW_HALF < 2 || FAST_HALF < 1 || FAST_HALF >= SLOW_HALF || FADE_STEP < 1) begin
      $error("bsi_io: bad timing parameters");
    end
  end

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic btn_s, src_s, flt_s, spa_s, spb_s, dpw_s, lsa_s, lsb_s;
  logic [7:0] sync_d, sync_q;
  assign sync_d = {push_button_in, power_source_in, power_fault_in, spare_pin_a_in,
                   spare_pin_b_in, drive_power_pin_in, link_state_ind_a_in, link_state_ind_b_in};
  // one synchroniser per pin keeps metastability off the logic
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      bsi_sync2 u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(sync_d[gi]),
        .q(sync_q[gi])
      );
    end
  endgenerate
  assign {btn_s, src_s, flt_s, spa_s, spb_s, dpw_s, lsa_s, lsb_s} = sync_q;

  // ************************************************************
  // APB slave
  // ************************************************************
  logic [31:0] ctrl_reg, spare_reg;
  logic [1:0] link_reg;
  logic btn_prev_reg, btn_evt_reg;
  logic wr_en, rd_en, hit_ctrl, hit_link, hit_spare, hit_stat, mapped;
  logic btn_rise, btn_clr;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign hit_ctrl = paddr == BSI_CTRL_OFS;
  assign hit_link = paddr == BSI_LINK_OFS;
  assign hit_spare = paddr == BSI_SPARE_OFS;
  assign hit_stat = paddr == BSI_STAT_OFS;
  assign mapped = hit_ctrl || hit_link || hit_spare || hit_stat;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // momentary press latched as an edge; read of status clears it
  assign btn_rise = btn_s && !btn_prev_reg;
  assign btn_clr = rd_en && hit_stat;

  // register writes; firmware sets ready only after its load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= BSI_CTRL_RST;
      link_reg <= BSI_U0;
      spare_reg <= BSI_SPARE_RST;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_reg <= pwdata;
      if (hit_link) link_reg <= pwdata[1:0];
      if (hit_spare) spare_reg <= pwdata;
    end
  end

  // press flag: set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_prev_reg <= 1'b0;
      btn_evt_reg <= 1'b0;
    end else begin
      btn_prev_reg <= btn_s;
      btn_evt_reg <= btn_rise || (btn_evt_reg && !btn_clr);
    end
  end

  // read mux, registered data output; fault level read as is, idle high by its pullup
  logic [31:0] rd_next;
  assign rd_next = hit_ctrl ? {ctrl_reg[31:7], ctrl_reg[6:0]} :
                   hit_link ? {30'h0, link_reg} :
                   hit_spare ? {28'h0, spare_reg[3:0]} :
                   hit_stat ? {23'h0, btn_evt_reg, lsb_s, lsa_s, dpw_s, spb_s, spa_s, flt_s, src_s, btn_s} :
                   32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) prdata <= rd_next;
  end

  // ************************************************************
  // pin control
  // ************************************************************
  logic ready, lpm_en;
  logic [1:0] ls_pat;
  assign ready = ctrl_reg[BSI_C_READY];
  assign lpm_en = ready && ctrl_reg[BSI_C_LPM];
  // U-state to pattern a/b; unused states fall to off/off
  assign ls_pat = (link_reg == BSI_U1) ? 2'b01 :
                  (link_reg == BSI_U2) ? 2'b10 :
                  (link_reg == BSI_U3) ? 2'b11 : 2'b00;
  logic dpw_en;
  // power-enable duty only when built in
  assign dpw_en = DRIVE_POWER_OPT && ready;

  // outputs from flops; pins released to pulls until firmware ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_state_ind_a_oe <= 1'b0;
      link_state_ind_a_out <= 1'b0;
      link_state_ind_b_oe <= 1'b0;
      link_state_ind_b_out <= 1'b0;
      spare_pin_a_oe <= 1'b0;
      spare_pin_a_out <= 1'b0;
      spare_pin_b_oe <= 1'b0;
      spare_pin_b_out <= 1'b0;
      drive_power_pin_oe <= 1'b0;
      drive_power_pin_out <= 1'b0;
    end else begin
      link_state_ind_a_oe <= lpm_en;
      link_state_ind_a_out <= lpm_en && ls_pat[0];
      link_state_ind_b_oe <= lpm_en;
      link_state_ind_b_out <= lpm_en && ls_pat[1];
      spare_pin_a_oe <= ready && spare_reg[BSI_S_OE];
      spare_pin_a_out <= ready && spare_reg[BSI_S_LVL];
      spare_pin_b_oe <= ready && spare_reg[BSI_S_OE + 1];
      spare_pin_b_out <= ready && spare_reg[BSI_S_LVL + 1];
      drive_power_pin_oe <= dpw_en;
      drive_power_pin_out <= dpw_en && ctrl_reg[BSI_C_DPWR];
    end
  end

  // ************************************************************
  // primary indicator
  // ************************************************************
  bsi_led_mode_t mode;
  logic conn, suspended;
  assign conn = ctrl_reg[BSI_C_CONN];
  // a suspend flag or a connected U3 link both give the fade pattern
  assign suspended = ctrl_reg[BSI_C_SUSP] || (conn && link_reg == BSI_U3);
  assign mode = !ready ? BSI_LED_OFF :
                suspended ? BSI_LED_FADE :
                !conn ? BSI_LED_OFF :
                ctrl_reg[BSI_C_ACT] ? BSI_LED_BLINK : BSI_LED_ON;

  logic [31:0] blink_cnt_reg, fade_cnt_reg;
  logic blink_reg, fade_dir_reg;
  logic [BSI_PWM_BITS-1:0] level_reg, pwm_cnt_reg;
  logic [31:0] half;
  // speed picks the blink rate
  assign half = ctrl_reg[BSI_C_SS] ? 32'(FAST_HALF) : 32'(SLOW_HALF);

  // blink phase toggles every half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end else if (mode != BSI_LED_BLINK) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b1;
    end else if (blink_cnt_reg >= half - 32'h1) begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // triangle ramp of brightness for fading
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fade_cnt_reg <= 32'h0;
      fade_dir_reg <= 1'b0;
      level_reg <= '0;
    end else if (mode != BSI_LED_FADE) begin
      fade_cnt_reg <= 32'h0;
      fade_dir_reg <= 1'b0;
      level_reg <= '0;
    end else if (fade_cnt_reg >= 32'(FADE_STEP - 1)) begin
      fade_cnt_reg <= 32'h0;
      if (fade_dir_reg ? (level_reg == '0) : (level_reg == '1)) fade_dir_reg <= !fade_dir_reg;
      else level_reg <= fade_dir_reg ? level_reg - BSI_PWM_BITS'(1) : level_reg + BSI_PWM_BITS'(1);
    end else begin
      fade_cnt_reg <= fade_cnt_reg + 32'h1;
    end
  end

  // active-low drive: low means lit, so 0% duty is full on
  logic lit_next;
  assign lit_next = (mode == BSI_LED_ON) || (mode == BSI_LED_BLINK && blink_reg) ||
                    (mode == BSI_LED_FADE && pwm_cnt_reg < level_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_reg <= '0;
      primary_led_pwm <= 1'b1;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + BSI_PWM_BITS'(1);
      primary_led_pwm <= !lit_next;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  link_drive_a: assert property (!lpm_en |=> !link_state_ind_a_oe && !link_state_ind_b_oe)
    else $error("link pins driven while low power off");
  link_u3_a: assert property (lpm_en && link_reg == BSI_U3 |=> link_state_ind_a_out && link_state_ind_b_out)
    else $error("u3 pattern wrong");
  link_u0_a: assert property (link_reg == BSI_U0 |=> !link_state_ind_a_out && !link_state_ind_b_out)
    else $error("u0 pattern wrong");
  led_conn_a: assert property (mode == BSI_LED_ON |=> !primary_led_pwm)
    else $error("led not lit when connected");
  led_dark_a: assert property (mode == BSI_LED_OFF |=> primary_led_pwm)
    else $error("led lit when off");
  wait_ready_a: assert property (!ready |=> !spare_pin_a_oe && !spare_pin_b_oe && !drive_power_pin_oe)
    else $error("pin driven before ready");
  spare_low_a: assert property (ready && spare_reg[BSI_S_OE] && !spare_reg[BSI_S_LVL]
    |=> spare_pin_a_oe && !spare_pin_a_out)
    else $error("spare pin not low output");
  no_dpw_a: assert property (!DRIVE_POWER_OPT |-> !drive_power_pin_oe)
    else $error("drive power pin driven without option");
  btn_hold_a: assert property (btn_rise |=> btn_evt_reg)
    else $error("button press lost");
endmodule

// *** design/bsi_pkg.sv ***
// What this block does
// - link-state pins show U0 off/off, U1 on/off, U2 off/on, U3 on/on, else off/off.
// - link-state pins drive only when U1/U2 enabled; otherwise input with pulldown.
// - push-button pin is an input with pulldown, used as a momentary button.
// - power-fault pin is an input with pullup; its level flags a power fault.
// - two spare pins reset as pulled-down inputs; commands make them outputs low or high.
// - drive-power pin defaults to input, or drive power enable output by build option.
// - primary PWM LED lit while USB connected, dark while disconnected.
// - during disk activity the LED blinks 5 Hz at USB2 and 10 Hz at SuperSpeed.
// - while suspended or connected in U3 the LED fades gradually in brightness.
// - indicator and pin functions wait until firmware load from flash completes.
// - the PWM output is active low; duty 0% means LED fully lit.
package bsi_pkg;
  // ************************************************************
  // link states
  // ************************************************************
  localparam logic [1:0] BSI_U0 = 2'h0;
  localparam logic [1:0] BSI_U1 = 2'h1;
  localparam logic [1:0] BSI_U2 = 2'h2;
  localparam logic [1:0] BSI_U3 = 2'h3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int BSI_CLK_HZ = 50000000;
  localparam int BSI_BLINK_SLOW_HZ = 5;
  localparam int BSI_BLINK_FAST_HZ = 10;
  // half-period of a blink, in cycles
  localparam int BSI_SLOW_HALF = BSI_CLK_HZ / (2 * BSI_BLINK_SLOW_HZ);
  localparam int BSI_FAST_HALF = BSI_CLK_HZ / (2 * BSI_BLINK_FAST_HZ);
  localparam int BSI_FADE_STEP = 50000;  // 1 ms per brightness step
  localparam int BSI_PWM_BITS = 8;

  // ************************************************************
  // APB register map
  // ************************************************************
  localparam logic [7:0] BSI_CTRL_OFS = 8'h00;
  localparam logic [7:0] BSI_LINK_OFS = 8'h04;
  localparam logic [7:0] BSI_SPARE_OFS = 8'h08;
  localparam logic [7:0] BSI_STAT_OFS = 8'h0c;
  // ctrl fields
  localparam int BSI_C_READY = 0;
  localparam int BSI_C_LPM = 1;
  localparam int BSI_C_CONN = 2;
  localparam int BSI_C_SS = 3;
  localparam int BSI_C_ACT = 4;
  localparam int BSI_C_SUSP = 5;
  localparam int BSI_C_DPWR = 6;
  // spare fields: [1:0] output enables, [3:2] levels
  localparam int BSI_S_OE = 0;
  localparam int BSI_S_LVL = 2;
  localparam logic [31:0] BSI_CTRL_RST = 32'h0;
  localparam logic [31:0] BSI_SPARE_RST = 32'h0;

  typedef enum logic [1:0] {BSI_LED_OFF, BSI_LED_ON, BSI_LED_BLINK, BSI_LED_FADE} bsi_led_mode_t;
endpackage

// *** design/bsi_sync2.sv ***
`timescale 1ns/1ns
// two-flop synchroniser for one level
module bsi_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic meta_reg;

  // ************************************************************
  // capture
  // ************************************************************
  // first flop feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
